/* core/ssr_pkg.sv */
package ssr_pkg;

	localparam int ADDR_W = 12;
	localparam int DATA_W = 8;
	localparam int BIAS_W = 6;
	localparam int BAND_W = 9;
	localparam int TEMP_W = 9;
	localparam int ADC_W = 10;
	localparam int PHASE_W = 17;
	localparam int BLEED_W = 16;
	localparam int SYNC_W = 2;

	// register offsets
	localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h058;
	localparam logic [ADDR_W-1:0] OFS_CORE0_BIAS = 12'h059;
	localparam logic [ADDR_W-1:0] OFS_CORE1_BIAS = 12'h05a;
	localparam logic [ADDR_W-1:0] OFS_TEMP_LOW = 12'h05b;
	localparam logic [ADDR_W-1:0] OFS_TEMP_SIGN = 12'h05c;
	localparam logic [ADDR_W-1:0] OFS_BAND_LOW = 12'h05e;
	localparam logic [ADDR_W-1:0] OFS_BAND_HIGH = 12'h05f;
	localparam logic [ADDR_W-1:0] OFS_PHASE_LOW = 12'h061;
	localparam logic [ADDR_W-1:0] OFS_PHASE_MID = 12'h062;
	localparam logic [ADDR_W-1:0] OFS_PHASE_TOP = 12'h063;
	localparam logic [ADDR_W-1:0] OFS_BLEED_LOW = 12'h064;
	localparam logic [ADDR_W-1:0] OFS_BLEED_HIGH = 12'h065;
	localparam logic [ADDR_W-1:0] OFS_FIRST_BAND = 12'h066;
	localparam logic [ADDR_W-1:0] OFS_REVISION = 12'h067;

	// status bit positions
	localparam int STS_LOCK_BIT = 0;
	localparam int STS_CAL_BIT = 1;
	localparam int STS_ADC_BIT = 2;
	localparam int STS_REF_BIT = 3;
	localparam int STS_DIR_BIT = 4;

	// temperature sign bit position within the 9-bit value
	localparam int TEMP_SIGN_BIT = 8;
	// largest magnitude that fits in the low byte
	localparam logic [DATA_W-1:0] TEMP_MAG_MAX = 8'hff;

	// arbitrary revision value
	localparam logic [DATA_W-1:0] REVISION_VALUE = 8'h01;

	localparam logic [DATA_W-1:0] RESET_BYTE = 8'h00;
	localparam logic [PHASE_W-1:0] PHASE_ONE = 17'h00001;

	// cycles after reset release before synchronised pins are trusted
	localparam logic [1:0] SETTLE_DONE = 2'h3;

endpackage

/* core/ssr_sync2.sv */
`timescale 1ns/1ps

// two-stage level synchroniser, one chain per bit
module ssr_sync2 #(
	parameter int WIDTH = 1
) (
	input  wire logic             ref_clk,
	input  wire logic             reset_n,
	input  wire logic [WIDTH-1:0] asyncIn,
	output logic      [WIDTH-1:0] syncOut
);
	import ssr_pkg::*;

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			logic [SYNC_W-1:0] chain_q;
			always_ff @(posedge ref_clk) begin
				if (!reset_n) begin
					chain_q <= '0;
				end else begin
					chain_q <= {chain_q[0], asyncIn[i]};
				end
			end
			assign syncOut[i] = chain_q[SYNC_W-1];
		end
	endgenerate

endmodule

/* core/ssr_status_regs.sv */
`timescale 1ns/1ps

module ssr_status_regs (
	input  wire logic                           ref_clk,
	input  wire logic                           reset_n,
	input  wire logic                           regRdStrobe,
	input  wire logic                           regWrStrobe,
	input  wire logic [ssr_pkg::ADDR_W-1:0]     regAddr,
	output logic      [ssr_pkg::DATA_W-1:0]     regRdData,
	output logic                                regRdValid,
	output logic                                regWrIgnored,
	input  wire logic                           lockDetectRaw,
	input  wire logic                           refAmpOkRaw,
	input  wire logic                           phaseStepPulse,
	input  wire logic                           phaseStepUp,
	input  wire logic                           adcStartPulse,
	input  wire logic                           adcDonePulse,
	input  wire logic signed [ssr_pkg::ADC_W-1:0] adcTempResult,
	input  wire logic                           calStartPulse,
	input  wire logic                           calFirstPassPulse,
	input  wire logic                           calDonePulse,
	input  wire logic [ssr_pkg::BAND_W-1:0]     calBand,
	input  wire logic                           calCore,
	input  wire logic [ssr_pkg::BIAS_W-1:0]     core0Bias,
	input  wire logic [ssr_pkg::BIAS_W-1:0]     core1Bias,
	input  wire logic [ssr_pkg::BLEED_W-1:0]    bleedCode
);
	import ssr_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers

	logic [1:0] pinSync;
	logic       lockSync;
	logic       refOkSync;

	ssr_sync2 #(
		.WIDTH (2)
	) u_sync (
		.ref_clk (ref_clk),
		.reset_n (reset_n),
		.asyncIn ({refAmpOkRaw, lockDetectRaw}),
		.syncOut (pinSync)
	);

	assign lockSync  = pinSync[0];
	assign refOkSync = pinSync[1];

	////////////////////////////////////////////////////////////////////////
	// state registers

	logic                  stepDir_q;
	logic                  adcBusy_q;
	logic                  calBusy_q;
	logic [BIAS_W-1:0]     core0Bias_q;
	logic [BIAS_W-1:0]     core1Bias_q;
	logic [DATA_W-1:0]     tempMag_q;
	logic [DATA_W-1:0]     tempMag_d;
	logic                  tempSign_q;
	logic [BAND_W-1:0]     band_q;
	logic                  core_q;
	logic [DATA_W-1:0]     firstBand_q;
	logic [PHASE_W-1:0]    phaseTotal_q;
	logic [PHASE_W-1:0]    phaseTotal_d;
	logic [BLEED_W-1:0]    bleed_q;
	logic [1:0]            settle_q;

	// direction of latest step
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			stepDir_q <= 1'b0;
		end else if (phaseStepPulse) begin
			stepDir_q <= phaseStepUp;
		end
	end

	// running total, one count per step
	assign phaseTotal_d = phaseStepUp ? phaseTotal_q + PHASE_ONE
		: phaseTotal_q - PHASE_ONE;

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			phaseTotal_q <= '0;
		end else if (phaseStepPulse) begin
			phaseTotal_q <= phaseTotal_d;
		end
	end

	// start wins over a done in the same cycle
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			adcBusy_q <= 1'b0;
		end else if (adcStartPulse) begin
			adcBusy_q <= 1'b1;
		end else if (adcDonePulse) begin
			adcBusy_q <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			calBusy_q <= 1'b0;
		end else if (calStartPulse) begin
			calBusy_q <= 1'b1;
		end else if (calDonePulse) begin
			calBusy_q <= 1'b0;
		end
	end

	// two's complement result to sign-magnitude, saturating
	logic [ADC_W-1:0] tempAbs;
	logic             tempOver;

	assign tempAbs   = adcTempResult[ADC_W-1] ? -adcTempResult : adcTempResult;
	assign tempOver  = |tempAbs[ADC_W-1:DATA_W];
	assign tempMag_d = tempOver ? TEMP_MAG_MAX : tempAbs[DATA_W-1:0];

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			tempMag_q  <= RESET_BYTE;
			tempSign_q <= 1'b0;
		end else if (adcDonePulse) begin
			tempMag_q  <= tempMag_d;
			tempSign_q <= adcTempResult[ADC_W-1];
		end
	end

	// calibration results
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			firstBand_q <= RESET_BYTE;
		end else if (calFirstPassPulse) begin
			firstBand_q <= calBand[DATA_W-1:0];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			band_q <= '0;
			core_q <= 1'b0;
		end else if (calDonePulse) begin
			band_q <= calBand;
			core_q <= calCore;
		end
	end

	// live values sampled every cycle
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			core0Bias_q <= '0;
			core1Bias_q <= '0;
			bleed_q     <= '0;
		end else begin
			core0Bias_q <= core0Bias;
			core1Bias_q <= core1Bias;
			bleed_q     <= bleedCode;
		end
	end

	// age since reset, for checks on synchronised pins
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			settle_q <= 2'h0;
		end else if (settle_q != SETTLE_DONE) begin
			settle_q <= settle_q + 2'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read decode

	logic [DATA_W-1:0] statusWord;
	logic [DATA_W-1:0] readMux;
	logic              addrHit;

	assign statusWord = {3'h0, stepDir_q, refOkSync, adcBusy_q, calBusy_q,
		lockSync};

	always_comb begin
		readMux = RESET_BYTE;
		addrHit = 1'b1;
		case (regAddr)
			OFS_STATUS:     readMux = statusWord;
			OFS_CORE0_BIAS: readMux = {2'h0, core0Bias_q};
			OFS_CORE1_BIAS: readMux = {2'h0, core1Bias_q};
			OFS_TEMP_LOW:   readMux = tempMag_q;
			OFS_TEMP_SIGN:  readMux = {7'h00, tempSign_q};
			OFS_BAND_LOW:   readMux = band_q[DATA_W-1:0];
			OFS_BAND_HIGH:  readMux = {6'h00, core_q, band_q[BAND_W-1]};
			OFS_PHASE_LOW:  readMux = phaseTotal_q[DATA_W-1:0];
			OFS_PHASE_MID:  readMux = phaseTotal_q[2*DATA_W-1:DATA_W];
			OFS_PHASE_TOP:  readMux = {7'h00, phaseTotal_q[PHASE_W-1]};
			OFS_BLEED_LOW:  readMux = bleed_q[DATA_W-1:0];
			OFS_BLEED_HIGH: readMux = bleed_q[2*DATA_W-1:DATA_W];
			OFS_FIRST_BAND: readMux = firstBand_q;
			OFS_REVISION:   readMux = REVISION_VALUE;
			default: begin
				readMux = RESET_BYTE;
				addrHit = 1'b0;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			regRdData  <= RESET_BYTE;
			regRdValid <= 1'b0;
		end else begin
			regRdData  <= regRdStrobe ? readMux : RESET_BYTE;
			regRdValid <= regRdStrobe;
		end
	end

	// writes change nothing, acknowledged only at mapped offsets
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			regWrIgnored <= 1'b0;
		end else begin
			regWrIgnored <= regWrStrobe && addrHit;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// assertions

	property p_dir_follows_step;
		@(posedge ref_clk) disable iff (!reset_n)
		phaseStepPulse |=> stepDir_q == $past(phaseStepUp);
	endproperty
	a_dir_follows_step: assert property (p_dir_follows_step)
		else $error("step direction not captured");

	property p_ref_ok_bit;
		@(posedge ref_clk) disable iff (!reset_n)
		(settle_q == SETTLE_DONE) |-> statusWord[STS_REF_BIT] == $past(refAmpOkRaw, 2);
	endproperty
	a_ref_ok_bit: assert property (p_ref_ok_bit)
		else $error("reference status bit wrong");

	property p_adc_busy_span;
		@(posedge ref_clk) disable iff (!reset_n)
		adcStartPulse ##1 (!adcDonePulse)[*2] |=> statusWord[STS_ADC_BIT];
	endproperty
	a_adc_busy_span: assert property (p_adc_busy_span)
		else $error("conversion busy dropped early");

	property p_cal_busy_end;
		@(posedge ref_clk) disable iff (!reset_n)
		(calDonePulse && !calStartPulse) |=> !statusWord[STS_CAL_BIT];
	endproperty
	a_cal_busy_end: assert property (p_cal_busy_end)
		else $error("calibration busy not cleared");

	property p_core0_read;
		@(posedge ref_clk) disable iff (!reset_n)
		(regRdStrobe && regAddr == OFS_CORE0_BIAS && $past(reset_n))
			|=> regRdValid && regRdData == {2'h0, $past(core0Bias, 2)};
	endproperty
	a_core0_read: assert property (p_core0_read)
		else $error("core 0 bias readback wrong");

	property p_core1_read;
		@(posedge ref_clk) disable iff (!reset_n)
		(regRdStrobe && regAddr == OFS_CORE1_BIAS && $past(reset_n))
			|=> regRdData == {2'h0, $past(core1Bias, 2)};
	endproperty
	a_core1_read: assert property (p_core1_read)
		else $error("core 1 bias readback wrong");

	property p_temp_sign;
		@(posedge ref_clk) disable iff (!reset_n)
		adcDonePulse |=> tempSign_q == $past(adcTempResult[ADC_W-1]);
	endproperty
	a_temp_sign: assert property (p_temp_sign)
		else $error("temperature sign wrong");

	property p_temp_sign_read;
		@(posedge ref_clk) disable iff (!reset_n)
		(regRdStrobe && regAddr == OFS_TEMP_SIGN)
			|=> regRdData == {7'h00, $past(tempSign_q)};
	endproperty
	a_temp_sign_read: assert property (p_temp_sign_read)
		else $error("temperature sign byte wrong");

	property p_first_band;
		@(posedge ref_clk) disable iff (!reset_n)
		calFirstPassPulse |=> firstBand_q == $past(calBand[DATA_W-1:0]);
	endproperty
	a_first_band: assert property (p_first_band)
		else $error("first pass band not kept");

	property p_bleed_high;
		@(posedge ref_clk) disable iff (!reset_n)
		(regRdStrobe && regAddr == OFS_BLEED_HIGH && $past(reset_n))
			|=> regRdData == $past(bleedCode[15:8], 2);
	endproperty
	a_bleed_high: assert property (p_bleed_high)
		else $error("bleed high byte wrong");

	property p_phase_top;
		@(posedge ref_clk) disable iff (!reset_n)
		(regRdStrobe && regAddr == OFS_PHASE_TOP)
			|=> regRdData[DATA_W-1:1] == 7'h00
			&& regRdData[0] == $past(phaseTotal_q[PHASE_W-1]);
	endproperty
	a_phase_top: assert property (p_phase_top)
		else $error("phase total top byte wrong");

	property p_lock_bit;
		@(posedge ref_clk) disable iff (!reset_n)
		(settle_q == SETTLE_DONE) |-> statusWord[STS_LOCK_BIT] == $past(lockDetectRaw, 2);
	endproperty
	a_lock_bit: assert property (p_lock_bit)
		else $error("lock status bit wrong");

	property p_write_ignored;
		@(posedge ref_clk) disable iff (!reset_n)
		(regWrStrobe && !phaseStepPulse && !calFirstPassPulse)
			|=> $stable(phaseTotal_q) && $stable(firstBand_q);
	endproperty
	a_write_ignored: assert property (p_write_ignored)
		else $error("write altered readback state");

	property p_unmapped_zero;
		@(posedge ref_clk) disable iff (!reset_n)
		(regRdStrobe && !addrHit) |=> regRdValid && regRdData == RESET_BYTE;
	endproperty
	a_unmapped_zero: assert property (p_unmapped_zero)
		else $error("unmapped read not zero");

endmodule

/* test/ssr_host_model.sv */
`timescale 1ns/1ps

// serial host side: one register access at a time
module ssr_host_model (
	input  wire logic                       ref_clk,
	output logic                            regRdStrobe,
	output logic                            regWrStrobe,
	output logic [ssr_pkg::ADDR_W-1:0]      regAddr,
	input  wire logic [ssr_pkg::DATA_W-1:0] regRdData,
	input  wire logic                       regRdValid,
	input  wire logic                       regWrIgnored
);
	import ssr_pkg::*;

	initial begin
		regRdStrobe = 1'b0;
		regWrStrobe = 1'b0;
		regAddr = 12'h000;
	end

	// idle address is scrambled so stale values never pass
	task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d, output logic v);
		@(negedge ref_clk);
		regRdStrobe = 1'b1;
		regAddr = a;
		@(negedge ref_clk);
		regRdStrobe = 1'b0;
		regAddr = ~a;
		d = regRdData;
		v = regRdValid;
	endtask

	task automatic wr(input logic [ADDR_W-1:0] a, output logic ig);
		@(negedge ref_clk);
		regWrStrobe = 1'b1;
		regAddr = a;
		@(negedge ref_clk);
		regWrStrobe = 1'b0;
		regAddr = ~a;
		ig = regWrIgnored;
	endtask
endmodule

/* test/synth_status_readback_regs_bench.sv */
`timescale 1ns/1ps

module synth_status_readback_regs_bench;
	import ssr_pkg::*;

	logic                     ref_clk = 1'b0;
	logic                     reset_n = 1'b0;
	logic                     regRdStrobe, regWrStrobe, regRdValid, regWrIgnored;
	logic [ADDR_W-1:0]        regAddr;
	logic [DATA_W-1:0]        regRdData;
	logic                     lockDetectRaw = 1'b0, refAmpOkRaw = 1'b0;
	logic                     phaseStepPulse = 1'b0, phaseStepUp = 1'b0;
	logic                     adcStartPulse = 1'b0, adcDonePulse = 1'b0;
	logic                     calStartPulse = 1'b0, calFirstPassPulse = 1'b0;
	logic                     calDonePulse = 1'b0, calCore = 1'b0;
	logic signed [ADC_W-1:0]  adcTempResult = '0;
	logic [BAND_W-1:0]        calBand = '0;
	logic [BIAS_W-1:0]        core0Bias = '0, core1Bias = '0;
	logic [BLEED_W-1:0]       bleedCode = '0;
	int                       fail_count = 0, total_checks = 0;
	integer                   seed = 32'h09a9;
	int                       mTemp = 0, mPhase = 0, mBand = 0, mFirst = 0;
	bit                       mAdc = 0, mCal = 0, mDir = 0, mCore = 0;
	logic                     ig;
	int                       temps [6] = '{-300, -1, 0, 100, 255, 256};
	logic [ADDR_W-1:0]        addrs [15] = '{OFS_STATUS, OFS_CORE0_BIAS, OFS_CORE1_BIAS,
		OFS_TEMP_LOW, OFS_TEMP_SIGN, OFS_BAND_LOW, OFS_BAND_HIGH, OFS_PHASE_LOW,
		OFS_PHASE_MID, OFS_PHASE_TOP, OFS_BLEED_LOW, OFS_BLEED_HIGH, OFS_FIRST_BAND,
		OFS_REVISION, 12'h05d};

	always #2.5 ref_clk = ~ref_clk;

	ssr_status_regs dut (.ref_clk(ref_clk), .reset_n(reset_n), .regRdStrobe(regRdStrobe),
		.regWrStrobe(regWrStrobe), .regAddr(regAddr), .regRdData(regRdData),
		.regRdValid(regRdValid), .regWrIgnored(regWrIgnored), .lockDetectRaw(lockDetectRaw),
		.refAmpOkRaw(refAmpOkRaw), .phaseStepPulse(phaseStepPulse), .phaseStepUp(phaseStepUp),
		.adcStartPulse(adcStartPulse), .adcDonePulse(adcDonePulse),
		.adcTempResult(adcTempResult), .calStartPulse(calStartPulse),
		.calFirstPassPulse(calFirstPassPulse), .calDonePulse(calDonePulse), .calBand(calBand),
		.calCore(calCore), .core0Bias(core0Bias), .core1Bias(core1Bias), .bleedCode(bleedCode));

	ssr_host_model host (.ref_clk(ref_clk), .regRdStrobe(regRdStrobe),
		.regWrStrobe(regWrStrobe), .regAddr(regAddr), .regRdData(regRdData),
		.regRdValid(regRdValid), .regWrIgnored(regWrIgnored));

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] expByte(input logic [ADDR_W-1:0] a);
		int m;
		m = (mTemp < 0) ? -mTemp : mTemp;
		if (m > 255) m = 255;
		case (a)
			OFS_STATUS: return {3'h0, mDir, refAmpOkRaw, mAdc, mCal, lockDetectRaw};
			OFS_CORE0_BIAS: return {2'h0, core0Bias};
			OFS_CORE1_BIAS: return {2'h0, core1Bias};
			OFS_TEMP_LOW: return 8'(m);
			OFS_TEMP_SIGN: return {7'h0, mTemp < 0};
			OFS_BAND_LOW: return 8'(mBand);
			OFS_BAND_HIGH: return {6'h0, mCore, mBand[8]};
			OFS_PHASE_LOW: return 8'(mPhase);
			OFS_PHASE_MID: return 8'(mPhase >> 8);
			OFS_PHASE_TOP: return {7'h0, mPhase[16]};
			OFS_BLEED_LOW: return bleedCode[7:0];
			OFS_BLEED_HIGH: return bleedCode[15:8];
			OFS_FIRST_BAND: return 8'(mFirst);
			OFS_REVISION: return REVISION_VALUE;
			default: return 8'h00;
		endcase
	endfunction

	task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
		total_checks++;
		if (s !== e) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic rdchk(input logic [ADDR_W-1:0] a);
		logic [7:0] d;
		logic       v;
		host.rd(a, d, v);
		chk($sformatf("valid %h", a), {7'h0, v}, 8'h01);
		chk($sformatf("data %h", a), d, expByte(a));
	endtask

	task automatic stop_test;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	initial begin
		#100000;
		fail_count++;
		$display("[FAIL] watchdog expired");
		stop_test();
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (2) @(posedge ref_clk);
		@(negedge ref_clk) reset_n = 1'b1;
		for (int i = 0; i < 15; i++) rdchk(addrs[i]);
		$display("test reset values done");
		for (int i = 0; i < 15; i++) begin
			host.wr(addrs[i], ig);
			chk("write ack", {7'h0, ig}, {7'h0, i < 14});
			rdchk(addrs[i]);
		end
		$display("test writes done");
		for (int i = 0; i < 4; i++) begin
			@(negedge ref_clk) {lockDetectRaw, refAmpOkRaw} = 2'(i);
			repeat (3) @(negedge ref_clk);
			rdchk(OFS_STATUS);
		end
		$display("test pins done");
		for (int i = 0; i < 7; i++) begin
			@(negedge ref_clk) adcStartPulse = 1'b1;
			@(negedge ref_clk) adcStartPulse = 1'b0;
			mAdc = 1;
			rdchk(OFS_STATUS);
			mTemp = (i < 6) ? temps[i] : $random(seed) % 512;
			adcTempResult = 10'(mTemp);
			adcDonePulse = 1'b1;
			@(negedge ref_clk) adcDonePulse = 1'b0;
			mAdc = 0;
			rdchk(OFS_STATUS);
			rdchk(OFS_TEMP_LOW);
			rdchk(OFS_TEMP_SIGN);
		end
		// start and done in one cycle: busy stays set, result still taken
		@(negedge ref_clk) adcStartPulse = 1'b1;
		adcDonePulse = 1'b1;
		mTemp = -5;
		adcTempResult = 10'(mTemp);
		@(negedge ref_clk) adcStartPulse = 1'b0;
		adcDonePulse = 1'b0;
		mAdc = 1;
		rdchk(OFS_STATUS);
		rdchk(OFS_TEMP_LOW);
		rdchk(OFS_TEMP_SIGN);
		@(negedge ref_clk) adcDonePulse = 1'b1;
		@(negedge ref_clk) adcDonePulse = 1'b0;
		mAdc = 0;
		rdchk(OFS_STATUS);
		$display("test temperature done");
		for (int i = 0; i < 3; i++) begin
			@(negedge ref_clk) calStartPulse = 1'b1;
			@(negedge ref_clk) calStartPulse = 1'b0;
			mCal = 1;
			rdchk(OFS_STATUS);
			calBand = 9'($random(seed));
			mFirst = calBand[7:0];
			calFirstPassPulse = 1'b1;
			@(negedge ref_clk) calFirstPassPulse = 1'b0;
			rdchk(OFS_FIRST_BAND);
			calBand = 9'($random(seed));
			calCore = 1'($random(seed));
			mBand = calBand;
			mCore = calCore;
			calDonePulse = 1'b1;
			@(negedge ref_clk) calDonePulse = 1'b0;
			mCal = 0;
			for (int a = 0; a < 2; a++) rdchk(OFS_BAND_LOW + 12'(a));
			rdchk(OFS_FIRST_BAND);
			rdchk(OFS_STATUS);
		end
		$display("test calibration done");
		for (int i = 0; i < 40; i++) begin
			@(negedge ref_clk) phaseStepPulse = 1'b1;
			phaseStepUp = (i == 0) ? 1'b0 : 1'($random(seed));
			mDir = phaseStepUp;
			mPhase = (mPhase + (mDir ? 1 : -1)) & 32'h1ffff;
			if (i < 2 || i == 39) begin
				@(negedge ref_clk) phaseStepPulse = 1'b0;
				rdchk(OFS_STATUS);
				for (int a = 0; a < 3; a++) rdchk(OFS_PHASE_LOW + 12'(a));
			end
		end
		$display("test phase total done");
		for (int i = 0; i < 8; i++) begin
			@(negedge ref_clk) core0Bias = 6'($random(seed));
			core1Bias = 6'($random(seed));
			bleedCode = 16'($random(seed));
			rdchk(OFS_CORE0_BIAS);
			rdchk(OFS_CORE1_BIAS);
			rdchk(OFS_BLEED_LOW);
			rdchk(OFS_BLEED_HIGH);
		end
		$display("test live readback done");
		stop_test();
	end
endmodule
